// ===== src/rtcs_cfg.svh
// Purpose: constants of the rtc serial slave port
// Assumes: 20 MHz system clock
// Notes: times in their own unit, cycle counts derived
`ifndef RTCS_CFG_SVH
`define RTCS_CFG_SVH
`define RTCS_SLAVE_ADDR 7'h51
`define RTCS_PTR_BITS 4
`define RTCS_LAST_REG 4'hA
`define RTCS_CLK_MHZ 20
`define RTCS_HOLD_NS 300
`define RTCS_HOLD_CYC ((`RTCS_HOLD_NS * `RTCS_CLK_MHZ + 999) / 1000)
`endif

// ===== src/rtcs_pkg.sv
// Purpose: types of the rtc serial slave port
// Assumes: nothing
// Notes: register writes towards the register file travel as structs
package rtcs_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_MACK} rtcs_state_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] data;
   } rtcs_wr_t;
endpackage : rtcs_pkg

// ===== src/rtcs_buf2.sv
// Purpose: two-entry valid/ready buffer for received register writes
// Assumes: single clock domain
// Notes: full and empty are exact; ready drops only when both entries hold data
`timescale 1ns/1ps
module rtcs_buf2 import rtcs_pkg::*; #(
   parameter int WIDTH = 12
) (
   input wire logic clk_sys_in, // system clock
   input wire logic rst_n_in, // async reset, active low
   input wire logic ce_in, // clock enable
   input wire logic in_valid_in, // word offered
   output logic in_ready_out, // buffer has room
   input wire logic [WIDTH-1:0] in_data_in, // word in
   output logic out_valid_out, // word available
   input wire logic out_ready_in, // sink takes word
   output logic [WIDTH-1:0] out_data_out // oldest word
);
   typedef struct packed {
      logic [1:0][WIDTH-1:0] mem;
      logic [1:0] cnt;
   } rtcs_buf_t;
   rtcs_buf_t s_q, s_d;
   logic push, pop;
   assign in_ready_out = (s_q.cnt != 2'h2);
   assign out_valid_out = (s_q.cnt != 2'h0);
   assign out_data_out = s_q.mem[0];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   always_comb begin
      s_d = s_q;
      if (pop) begin
         s_d.mem[0] = s_q.mem[1];
      end
      if (push) begin
         if (s_q.cnt == 2'h0 || (s_q.cnt == 2'h1 && pop)) begin
            s_d.mem[0] = in_data_in;
         end else begin
            s_d.mem[1] = in_data_in;
         end
      end
      s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
   end
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_q <= '0;
      end else if (ce_in) begin
         s_q <= s_d;
      end
   end
   a_buf_no_over: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      s_q.cnt <= 2'h2) else $error("buffer count above two");
endmodule : rtcs_buf2

// ===== src/rtcs_slave.sv
// Purpose: serial two-wire slave port of a small real-time clock
// Assumes: scl and sda sampled by clk_sys_in, bus much slower than 20 MHz
// Notes: register file lives outside; writes leave through a two-entry buffer
`timescale 1ns/1ps
`include "rtcs_cfg.svh"
// Summary of operation
// [R1] the port answers only the fixed address 1010001, sent msb first.
// [R2] the master sends the address byte right after every start.
// [R3] the eighth address bit picks write when 0 and read when 1.
// [R4] in a write, a stop or a new start ends the transfer.
// [R5] the first written byte loads the pointer from its low four bits only.
// [R6] a read follows a pointer write through either a repeated start or stop then start.
// [R7] the master finishes each access within one second.
// [R8] while an access runs the counters freeze and one pending second tick is kept.
// [R9] every received byte is acknowledged; a master reader nacks the last byte.
// [R10] the pointer steps after each data byte and wraps from the last register to zero.
module rtcs_slave import rtcs_pkg::*; #(
   parameter logic [3:0] LAST_REG = `RTCS_LAST_REG
) (
   input wire logic clk_sys_in, // system clock
   input wire logic rst_n_in, // async reset, active low
   input wire logic ce_in, // clock enable, freezes all state
   input wire logic scl_in, // bus clock pin
   input wire logic sda_in, // bus data pin level
   output logic sda_out, // data driven, always low
   output logic sda_oe_out, // high while pulling sda low
   output logic [3:0] rd_addr_out, // register being read
   input wire logic [7:0] rd_data_in, // register read data
   output logic wr_valid_out, // register write offered
   input wire logic wr_ready_in, // register file takes write
   output rtcs_wr_t wr_out, // register write address and data
   input wire logic tick_in, // one-second increment request
   output logic tick_out, // increment pulse to counters
   output logic busy_out // access in progress, counters frozen
);
   typedef struct packed {
      logic [1:0] scl_s, sda_s;
      logic scl_p, sda_p;
      rtcs_state_t st;
      logic [2:0] bitn;
      logic got;
      logic [7:0] sh;
      logic rd;
      logic first;
      logic [3:0] ptr;
      logic oe;
      logic [3:0] hold;
      logic pend;
      logic tick;
      logic busy;
   } rtcs_st_t;
   rtcs_st_t s_q, s_d;
   logic scl, sda, rise, fall, start, stop;
   logic push, push_rdy;
   rtcs_wr_t push_w;
   assign scl = s_q.scl_s[1];
   assign sda = s_q.sda_s[1];
   assign rise = scl && !s_q.scl_p;
   assign fall = !scl && s_q.scl_p;
   assign start = scl && s_q.scl_p && s_q.sda_p && !sda;
   assign stop = scl && s_q.scl_p && !s_q.sda_p && sda;
   // a word that meets a full buffer is still acked, as every byte must be, and is lost
   assign push = (s_q.st == ST_RX) && rise && (s_q.bitn == 3'h7) && !s_q.first;
   assign push_w = '{addr: s_q.ptr, data: {s_q.sh[6:0], sda}};
   function automatic logic [3:0] step(input logic [3:0] p);
      step = (p == LAST_REG) ? 4'h0 : p + 4'h1; // [R10]
   endfunction : step
   always_comb begin
      s_d = s_q;
      s_d.scl_s = {s_q.scl_s[0], scl_in};
      s_d.sda_s = {s_q.sda_s[0], sda_in};
      s_d.scl_p = scl;
      s_d.sda_p = sda;
      s_d.tick = 1'b0;
      if (s_q.hold != 4'h0) begin
         s_d.hold = s_q.hold - 4'h1;
      end
      if (start) begin
         s_d.st = ST_ADDR; // [R2] [R4] [R6]
         s_d.bitn = 3'h0;
         s_d.got = 1'b0;
         s_d.oe = 1'b0;
         s_d.busy = 1'b1;
      end else if (stop) begin
         s_d.st = ST_IDLE; // [R4]
         s_d.oe = 1'b0;
         s_d.busy = 1'b0;
      end else if (rise) begin
         s_d.sh = {s_q.sh[6:0], sda};
         s_d.bitn = s_q.bitn + 3'h1;
         s_d.got = (s_q.bitn == 3'h7);
         if (s_q.st == ST_MACK) begin
            // an ack reloads through the ack state so the next msb goes out on this fall
            s_d.st = sda ? ST_IDLE : ST_ACK; // [R9]
            s_d.ptr = step(s_q.ptr); // [R10]
         end
      end else if (fall && s_q.hold == 4'h0) begin
         unique case (s_q.st)
            ST_ADDR: if (s_q.bitn == 3'h0 && s_q.got) begin
               if (s_q.sh[7:1] == `RTCS_SLAVE_ADDR) begin // [R1]
                  s_d.st = ST_ACK;
                  s_d.rd = s_q.sh[0]; // [R3]
                  s_d.first = !s_q.sh[0];
                  s_d.oe = 1'b1;
               end else begin
                  s_d.st = ST_IDLE;
                  s_d.busy = 1'b0;
               end
            end
            ST_RX: if (s_q.bitn == 3'h0) begin
               s_d.st = ST_ACK; // [R9]
               s_d.oe = 1'b1;
               if (s_q.first) begin
                  s_d.ptr = s_q.sh[`RTCS_PTR_BITS-1:0]; // [R5]
                  s_d.first = 1'b0;
               end else begin
                  s_d.ptr = step(s_q.ptr); // [R10]
               end
            end
            ST_ACK: begin
               s_d.bitn = 3'h0;
               s_d.hold = 4'(`RTCS_HOLD_CYC);
               if (s_q.rd) begin
                  s_d.st = ST_TX;
                  s_d.sh = {rd_data_in[6:0], 1'b0};
                  s_d.oe = !rd_data_in[7];
               end else begin
                  s_d.st = ST_RX;
                  s_d.oe = 1'b0;
               end
            end
            ST_TX: begin
               s_d.hold = 4'(`RTCS_HOLD_CYC);
               if (s_q.bitn == 3'h0) begin
                  s_d.st = ST_MACK;
                  s_d.oe = 1'b0;
               end else begin
                  s_d.oe = !s_q.sh[7];
                  s_d.sh = {s_q.sh[6:0], 1'b0};
               end
            end
            default: ;
         endcase
      end
      if (s_q.st == ST_TX && rise) begin
         s_d.sh = s_q.sh;
      end
      // one tick stored while busy; a later one in the same access is dropped
      if (tick_in) begin
         s_d.pend = 1'b1; // [R8]
      end
      if (!s_q.busy && s_q.pend) begin
         s_d.tick = 1'b1; // [R8]
         s_d.pend = tick_in;
      end
   end
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_q <= '{scl_s: 2'h3, sda_s: 2'h3, scl_p: 1'b1, sda_p: 1'b1, st: ST_IDLE, default: '0};
      end else if (ce_in) begin
         s_q <= s_d;
      end
   end
   assign sda_out = 1'b0;
   assign sda_oe_out = s_q.oe;
   assign rd_addr_out = (s_q.st == ST_MACK) ? step(s_q.ptr) : s_q.ptr;
   assign tick_out = s_q.tick;
   assign busy_out = s_q.busy; // [R8]
   rtcs_buf2 #(
      .WIDTH($bits(rtcs_wr_t))
   ) u_buf (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .in_valid_in(push),
      .in_ready_out(push_rdy),
      .in_data_in(push_w),
      .out_valid_out(wr_valid_out),
      .out_ready_in(wr_ready_in),
      .out_data_out(wr_out)
   );
   a_no_tick_busy: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [R8]
      tick_out |-> !$past(busy_out)) else $error("tick while busy");
   a_ptr_wrap: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [R10]
      ce_in && !s_q.first && s_q.ptr == LAST_REG && s_d.ptr != s_q.ptr |=> s_q.ptr == 4'h0)
      else $error("pointer past last");
   a_stop_ends: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [R4]
      ce_in && stop |=> !busy_out && s_q.st == ST_IDLE) else $error("stop ignored");
   a_start_addr: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [R2]
      ce_in && start |=> s_q.st == ST_ADDR && !sda_oe_out) else $error("start lost");
   a_addr_match: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [R1]
      ce_in && s_q.st == ST_ADDR && fall && s_q.bitn == 3'h0 && s_q.got && s_q.hold == 4'h0
      && s_q.sh[7:1] != `RTCS_SLAVE_ADDR |=> s_q.st == ST_IDLE && !sda_oe_out)
      else $error("ack without address");
   a_ack_dir: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [R3]
      ce_in && s_q.st == ST_ADDR && fall && s_q.bitn == 3'h0 && s_q.got && s_q.hold == 4'h0
      && s_q.sh[7:1] == `RTCS_SLAVE_ADDR
      |=> s_q.rd == $past(s_q.sh[0]) && sda_oe_out) else $error("direction wrong");
   a_ptr_low4: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [R5]
      ce_in && s_q.st == ST_RX && s_q.first && fall && s_q.bitn == 3'h0 && s_q.hold == 4'h0
      |=> s_q.ptr == $past(s_q.sh[3:0])) else $error("pointer load wrong");
   a_rx_ack: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [R9]
      s_q.st == ST_ACK && !s_q.rd |-> s_q.oe || $past(push)) else $error("no ack");
   c_write: cover property (@(posedge clk_sys_in) wr_valid_out && wr_ready_in);
   c_read: cover property (@(posedge clk_sys_in) s_q.st == ST_MACK && rise && sda);
   c_restart: cover property (@(posedge clk_sys_in) start && busy_out);
   c_tick_held: cover property (@(posedge clk_sys_in) busy_out && tick_in);
   c_full_word: cover property (@(posedge clk_sys_in) push && !push_rdy);
endmodule : rtcs_slave

// ===== testbench/rtcs_mst_model.sv
// Purpose: behavioural two-wire bus master facing the rtc slave port
// Assumes: pull-up on data, so a released line reads high
// Notes: low phase stretched so slave data is settled after its hold time
`timescale 1ns/1ps
module rtcs_mst_model (
   input wire logic clk_in, // paces the bus
   input wire logic sda_in, // resolved data line
   output logic scl_out, // bus clock, idle high
   output logic sda_out // data, 1 = released
);
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge clk_in);
   endtask : wt
   // also serves as repeated start; the address byte always follows
   task automatic start();
      sda_out = 1'b1;
      wt(12);
      scl_out = 1'b1;
      wt(4);
      sda_out = 1'b0;
      wt(4);
      scl_out = 1'b0;
   endtask : start
   task automatic stop();
      sda_out = 1'b0;
      wt(12);
      scl_out = 1'b1;
      wt(4);
      sda_out = 1'b1;
      wt(4);
   endtask : stop
   // each access lasts microseconds, far below one second
   task automatic xbit(input logic b, output logic r);
      sda_out = b;
      wt(12);
      scl_out = 1'b1;
      wt(3);
      r = sda_in;
      wt(1);
      scl_out = 1'b0;
   endtask : xbit
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xbit(d[i], r); // msb first
      xbit(1'b1, r);
      ack = ~r;
   endtask : wr_byte
   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
      xbit(last, r); // nack only the last byte
   endtask : rd_byte
endmodule : rtcs_mst_model

// ===== testbench/rtc_i2c_slave_port_tb_top.sv
// Purpose: self-checking bench of the rtc serial slave port
// Assumes: behavioural bus master, register file modelled as a pattern
// Notes: write sink stalls until pop, so the two-entry buffer fills
`timescale 1ns/1ps
module rtc_i2c_slave_port_tb_top import rtcs_pkg::*;;
   logic clk = 1'b0, rst_n = 1'b0, wr_ready = 1'b0, tick = 1'b0;
   logic scl, msda, sda_o, sda_oe, wr_valid, tick_o, busy, a;
   logic [3:0] rd_addr;
   logic [7:0] rd_data = 8'h00, d;
   rtcs_wr_t wr;
   int n_mismatch = 0, cmp_count = 0, n_tick = 0, n0;
   wire logic sda_w = sda_oe ? (msda & sda_o) : msda;
   rtcs_slave rtcs_slave_i (.clk_sys_in(clk), .rst_n_in(rst_n), .ce_in(1'b1),
      .scl_in(scl), .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe),
      .rd_addr_out(rd_addr), .rd_data_in(rd_data), .wr_valid_out(wr_valid),
      .wr_ready_in(wr_ready), .wr_out(wr), .tick_in(tick), .tick_out(tick_o),
      .busy_out(busy));
   rtcs_mst_model rtcs_mst_model_i (.clk_in(clk), .sda_in(sda_w), .scl_out(scl),
      .sda_out(msda));
   initial begin
      forever #25 clk = ~clk;
   end
   always @(negedge clk) rd_data <= {4'hC, rd_addr};
   always @(posedge clk) if (tick_o === 1'b1) n_tick++;
   task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out
   task automatic pop(input logic [11:0] exp);
      int k;
      k = 0;
      while (wr_valid !== 1'b1 && k < 400) begin
         @(negedge clk);
         k++;
      end
      if (k == 400) begin
         n_mismatch++;
         close_out();
      end else begin
         chk("write word", wr, exp);
         wr_ready = 1'b1;
         @(negedge clk);
         wr_ready = 1'b0;
         @(negedge clk);
      end
   endtask : pop
   task automatic t_write();
      rtcs_mst_model_i.start();
      rtcs_mst_model_i.wr_byte(8'hA2, a);
      chk("address ack", a, 12'h1);
      chk("busy", busy, 12'h1);
      rtcs_mst_model_i.wr_byte(8'hF4, a);
      rtcs_mst_model_i.wr_byte(8'h12, a);
      chk("data ack", a, 12'h1);
      rtcs_mst_model_i.stop();
      pop(12'h412);
      $display("test write done");
   endtask : t_write
   task automatic t_fill();
      rtcs_mst_model_i.start();
      rtcs_mst_model_i.wr_byte(8'hA2, a);
      rtcs_mst_model_i.wr_byte(8'h0A, a);
      rtcs_mst_model_i.wr_byte(8'h55, a);
      rtcs_mst_model_i.wr_byte(8'h66, a);
      chk("second ack", a, 12'h1);
      rtcs_mst_model_i.wr_byte(8'h77, a);
      chk("full ack", a, 12'h1);
      rtcs_mst_model_i.stop();
      pop(12'hA55);
      pop(12'h066);
      chk("drained", wr_valid, 12'h0);
      $display("test fill done");
   endtask : t_fill
   task automatic t_read();
      rtcs_mst_model_i.start();
      rtcs_mst_model_i.wr_byte(8'hA2, a);
      rtcs_mst_model_i.wr_byte(8'h09, a);
      rtcs_mst_model_i.start();
      rtcs_mst_model_i.wr_byte(8'hA3, a);
      chk("read ack", a, 12'h1);
      for (int i = 0; i < 3; i++) begin
         rtcs_mst_model_i.rd_byte(i == 2, d);
         chk("read byte", d, (i == 2) ? 12'h0C0 : 12'h0C9 + 12'(i));
      end
      rtcs_mst_model_i.stop();
      rtcs_mst_model_i.start();
      rtcs_mst_model_i.wr_byte(8'hA3, a);
      rtcs_mst_model_i.rd_byte(1'b1, d);
      rtcs_mst_model_i.stop();
      chk("read after stop", d, 12'h0C1);
      chk("no write", wr_valid, 12'h0);
      $display("test read done");
   endtask : t_read
   task automatic t_other();
      rtcs_mst_model_i.start();
      rtcs_mst_model_i.wr_byte(8'hA4, a);
      chk("foreign nack", a, 12'h0);
      rtcs_mst_model_i.wt(8);
      chk("idle busy", busy, 12'h0);
      rtcs_mst_model_i.stop();
      $display("test foreign address done");
   endtask : t_other
   task automatic t_tick();
      n0 = n_tick;
      rtcs_mst_model_i.start();
      rtcs_mst_model_i.wr_byte(8'hA2, a);
      for (int i = 0; i < 2; i++) begin
         tick = 1'b1;
         @(negedge clk);
         tick = 1'b0;
         rtcs_mst_model_i.wt(5);
      end
      chk("frozen", 12'(n_tick - n0), 12'h0);
      rtcs_mst_model_i.stop();
      rtcs_mst_model_i.wt(20);
      chk("one held tick", 12'(n_tick - n0), 12'h1);
      $display("test tick done");
   endtask : t_tick
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_write();
      t_fill();
      t_read();
      t_other();
      t_tick();
      close_out();
   end
endmodule : rtc_i2c_slave_port_tb_top
